// [design/router_defines.svh]
// Register offsets, field positions and reset values of the router
`ifndef ROUTER_DEFINES_SVH
`define ROUTER_DEFINES_SVH

`define CFG_OFS        4'h0
`define VOL_ASSIGN_OFS 4'h4
`define STATUS_OFS     4'h8

`define CFG_MODE_BIT   0
`define CFG_BAND_LSB   1
`define CFG_BAND_MSB   2
`define CFG_PORTB_BIT  3
`define CFG_SYNC_LSB   4
`define CFG_SYNC_MSB   6

`define ST_STANDALONE_BIT 0
`define ST_PORTB_BIT      1
`define ST_BAND_LSB       2
`define ST_BAND_MSB       3

`define VOL_ASSIGN_RST 8'hff
`define KNOB_MAX       8'hff
`define GAIN_SHIFT     8
`define BAND_CODE_BAD  2'h3
`define FULL_CHANNELS  4'h8
`define HALF_CHANNELS  4'h4
`define QUAD_PER_PORT  2
`define DUAL_PER_PORT  4

`endif

// [design/router_pkg.sv]
// Types shared by the standalone router
package router_pkg;
    typedef enum logic {
        MODE_BIDIR,
        MODE_INPUT_ONLY
    } conv_mode_type;

    typedef enum logic [1:0] {
        BAND_SINGLE,
        BAND_DOUBLE,
        BAND_QUAD
    } rate_band_type;

    typedef enum logic {
        PORTB_LIGHTPIPE,
        PORTB_SPDIF
    } portb_format_type;
endpackage : router_pkg

// [design/standalone_converter_router.sv]
// Standalone channel router with its Avalon-MM register slave
// Operation
// - Converter mode is bidirectional or input-only.
// - Bidir single rate: eight channels, S/PDIF crossed.
// - Bidir double, lightpipe B: eight channels both ways.
// - Bidir double, S/PDIF B: four channels, S/PDIF crossed.
// - Bidir quad: port B lightpipe, four channels.
// - Double rate with lightpipe B splits four channels per port.
// - Quad rate splits two channels per port.
// - Input-only: analog inputs feed analog and optical.
// - Input-only single: eight channels, S/PDIF crossed.
// - Input-only double lightpipe: eight channels split.
// - Input-only double S/PDIF: four channels, crossed.
// - Input-only quad: lightpipe B, four channels.
// - Master volume attenuation persists unless cleared/maxed.
// - No host cable at power-up selects standalone.
// - S/PDIF limited to double rate; above forces lightpipe.
`timescale 1ns/1ps
`include "router_defines.svh"

module standalone_converter_router
    import router_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    // Avalon-MM slave
    input  wire logic [3:0]                   address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [31:0]                  writedata,
    output logic      [31:0]                  readdata,
    output logic                              waitrequest,
    // Power-up strap and front panel
    input  wire logic                         host_cable_present,
    input  wire logic [7:0]                   volume_knob,
    // Sample inputs, one word per channel per frame
    input  wire logic                         sample_valid,
    input  wire logic [CHANNELS-1:0][SAMPLE_W-1:0] analog_in,
    input  wire logic [CHANNELS-1:0][SAMPLE_W-1:0] optical_a_in,
    input  wire logic [CHANNELS-1:0][SAMPLE_W-1:0] optical_b_in,
    input  wire logic [1:0][SAMPLE_W-1:0]     coax_spdif_in,
    input  wire logic [1:0][SAMPLE_W-1:0]     optical_spdif_in,
    // Sample outputs
    output logic                              out_valid,
    output logic [CHANNELS-1:0][SAMPLE_W-1:0] analog_out,
    output logic [CHANNELS-1:0][SAMPLE_W-1:0] optical_a_out,
    output logic [CHANNELS-1:0][SAMPLE_W-1:0] optical_b_out,
    output logic [1:0][SAMPLE_W-1:0]          coax_spdif_out,
    output logic [1:0][SAMPLE_W-1:0]          optical_spdif_out,
    // Status
    output logic                              standalone_active,
    output logic [2:0]                        sync_source
);

    generate
        if (CHANNELS != 8 || SAMPLE_W < 8) begin : g_bad_params
            $error("router supports eight channels of at least 8 bits");
        end
    endgenerate

    // Configuration and status state
    conv_mode_type    mode_reg;
    rate_band_type    band_reg;
    portb_format_type portb_fmt_reg;
    logic [2:0]       sync_reg;
    logic [7:0]       vol_assign_reg;
    logic             standalone_reg;
    logic             strap_taken_reg;
    logic             waitrequest_reg;
    logic [31:0]      readdata_reg;
    logic             out_valid_reg;
    logic [CHANNELS-1:0][SAMPLE_W-1:0] analog_out_reg;
    logic [CHANNELS-1:0][SAMPLE_W-1:0] optical_a_out_reg;
    logic [CHANNELS-1:0][SAMPLE_W-1:0] optical_b_out_reg;
    logic [1:0][SAMPLE_W-1:0]          coax_out_reg;
    logic [1:0][SAMPLE_W-1:0]          opt_spdif_out_reg;

    logic             bus_take;
    portb_format_type portb_eff;
    logic [3:0]       active_channels;
    logic             spdif_on;
    logic [31:0]      status_word;

    assign bus_take = (read || write) && !waitrequest_reg;

    // Bus slave: each request stalls one cycle, then is taken
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            waitrequest_reg <= 1'b1;
        end else begin
            waitrequest_reg <= !((read || write) && waitrequest_reg);
        end
    end

    // is not a stored choice: the stored format only matters at double
    always_comb begin
        unique case (band_reg)
            BAND_SINGLE: portb_eff = PORTB_SPDIF;
            BAND_DOUBLE: portb_eff = portb_fmt_reg;
            BAND_QUAD:   portb_eff = PORTB_LIGHTPIPE;
            default:     portb_eff = PORTB_LIGHTPIPE;
        endcase
    end

    // Channel count mapped for this band and port B format
    always_comb begin
        unique case (band_reg)
            BAND_SINGLE: active_channels = `FULL_CHANNELS;
            BAND_DOUBLE: active_channels = (portb_eff == PORTB_SPDIF) ?
                `HALF_CHANNELS : `FULL_CHANNELS;
            BAND_QUAD:   active_channels = `HALF_CHANNELS;
            default:     active_channels = 4'h0;
        endcase
    end

    assign spdif_on = standalone_reg && (portb_eff == PORTB_SPDIF);

    always_comb begin
        status_word = 32'h0;
        status_word[`ST_STANDALONE_BIT] = standalone_reg;
        status_word[`ST_PORTB_BIT] = portb_eff;
        status_word[`ST_BAND_MSB:`ST_BAND_LSB] = band_reg;
    end

    // Loaded on the stall edge so the word already stands at the take edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            readdata_reg <= 32'h0;
        end else if (read && waitrequest_reg) begin
            unique case (address)
                `CFG_OFS:        readdata_reg <= {25'h0, sync_reg,
                                     portb_fmt_reg, band_reg, mode_reg};
                `VOL_ASSIGN_OFS: readdata_reg <= {24'h0, vol_assign_reg};
                `STATUS_OFS:     readdata_reg <= status_word;
                default:         readdata_reg <= 32'h0;
            endcase
        end
    end

    // Standalone settings, kept apart from any hosted configuration
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_reg      <= MODE_BIDIR;
            band_reg      <= BAND_SINGLE;
            portb_fmt_reg <= PORTB_SPDIF;
            sync_reg      <= 3'h0;
        end else if (bus_take && write && address == `CFG_OFS) begin
            mode_reg <= conv_mode_type'(writedata[`CFG_MODE_BIT]);
            // A reserved band code would leave the routing undefined
            if (writedata[`CFG_BAND_MSB:`CFG_BAND_LSB] != `BAND_CODE_BAD) begin
                band_reg <= rate_band_type'(
                    writedata[`CFG_BAND_MSB:`CFG_BAND_LSB]);
            end
            portb_fmt_reg <= portb_format_type'(writedata[`CFG_PORTB_BIT]);
            sync_reg      <= writedata[`CFG_SYNC_MSB:`CFG_SYNC_LSB];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            vol_assign_reg <= `VOL_ASSIGN_RST;
        end else if (bus_take && write && address == `VOL_ASSIGN_OFS) begin
            vol_assign_reg <= writedata[7:0];
        end
    end

    // Strap caught on the first edge after reset release
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            strap_taken_reg <= 1'b0;
            standalone_reg  <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            standalone_reg  <= !host_cable_present;
        end
    end

    // Per-channel routing
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_route
            localparam int HALF = CHANNELS / 2;
            localparam int QTR  = CHANNELS / 4;
            logic signed [SAMPLE_W-1:0]   opt_in_ch;
            logic signed [SAMPLE_W-1:0]   ana_src;
            logic signed [SAMPLE_W+8:0]   scaled;
            logic        [SAMPLE_W-1:0]   ana_next;
            logic        [SAMPLE_W-1:0]   opt_a_next;
            logic        [SAMPLE_W-1:0]   opt_b_next;
            logic                         mapped;

            assign mapped = standalone_reg &&
                (4'(ch) < active_channels);

            // Optical logical channel as split across ports
            always_comb begin
                unique case (band_reg)
                    BAND_DOUBLE: opt_in_ch = (ch < `DUAL_PER_PORT) ?
                        optical_a_in[ch] :
                        optical_b_in[(ch + HALF) % CHANNELS];
                    BAND_QUAD: opt_in_ch = (ch < `QUAD_PER_PORT) ?
                        optical_a_in[ch] :
                        optical_b_in[(ch + CHANNELS - QTR) % CHANNELS];
                    default: opt_in_ch = optical_a_in[ch];
                endcase
            end

            // Input-only bypasses D/A entirely
            assign ana_src = !mapped ? '0 :
                (mode_reg == MODE_INPUT_ONLY) ? analog_in[ch] :
                opt_in_ch;

            // Knob attenuation stays until unassigned or fully up
            assign scaled = ana_src * $signed({1'b0, volume_knob});
            assign ana_next = (!vol_assign_reg[ch] ||
                volume_knob == `KNOB_MAX) ? ana_src :
                scaled[SAMPLE_W+`GAIN_SHIFT-1:`GAIN_SHIFT];

            // Port A slot carries logical channel of the same number
            always_comb begin
                opt_a_next = '0;
                opt_b_next = '0;
                unique case (band_reg)
                    BAND_SINGLE: opt_a_next = mapped ? analog_in[ch] : '0;
                    BAND_DOUBLE: begin
                        if (ch < `DUAL_PER_PORT) begin
                            opt_a_next = mapped ? analog_in[ch] : '0;
                            if (portb_eff == PORTB_LIGHTPIPE) begin
                                opt_b_next = standalone_reg ?
                                    analog_in[(ch + `DUAL_PER_PORT) %
                                    CHANNELS] : '0;
                            end
                        end
                    end
                    BAND_QUAD: begin
                        if (ch < `QUAD_PER_PORT) begin
                            opt_a_next = mapped ? analog_in[ch] : '0;
                            opt_b_next = standalone_reg ?
                                analog_in[(ch + `QUAD_PER_PORT) %
                                CHANNELS] : '0;
                        end
                    end
                    default: opt_a_next = '0;
                endcase
            end

            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    analog_out_reg[ch]    <= '0;
                    optical_a_out_reg[ch] <= '0;
                    optical_b_out_reg[ch] <= '0;
                end else if (sample_valid) begin
                    analog_out_reg[ch]    <= ana_next;
                    optical_a_out_reg[ch] <= opt_a_next;
                    optical_b_out_reg[ch] <= opt_b_next;
                end
            end
        end
    endgenerate

    // S/PDIF cross-conversion, only while port B is in S/PDIF form
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            coax_out_reg      <= '0;
            opt_spdif_out_reg <= '0;
        end else if (sample_valid) begin
            coax_out_reg      <= spdif_on ? optical_spdif_in : '0;
            opt_spdif_out_reg <= spdif_on ? coax_spdif_in : '0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            out_valid_reg <= 1'b0;
        end else begin
            out_valid_reg <= sample_valid;
        end
    end

    assign readdata          = readdata_reg;
    assign waitrequest       = waitrequest_reg;
    assign out_valid         = out_valid_reg;
    assign analog_out        = analog_out_reg;
    assign optical_a_out     = optical_a_out_reg;
    assign optical_b_out     = optical_b_out_reg;
    assign coax_spdif_out    = coax_out_reg;
    assign optical_spdif_out = opt_spdif_out_reg;
    assign standalone_active = standalone_reg;
    assign sync_source       = sync_reg;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_stall_then_take;
        waitrequest ##1 !waitrequest;
    endsequence

    a_bus_one_wait: assert property (
        $rose(read || write) && waitrequest |-> ##1 !waitrequest)
        else $error("request not answered after one wait cycle");

    a_bus_mode_write: assert property (
        (write && !waitrequest && address == `CFG_OFS)
        |=> mode_reg == conv_mode_type'($past(writedata[`CFG_MODE_BIT])))
        else $error("converter mode write lost");

    a_strap_capture: assert property (
        !strap_taken_reg |=> standalone_reg == !$past(host_cable_present)
        ##1 $stable(standalone_reg))
        else $error("standalone strap not captured");

    a_quad_lightpipe: assert property (
        band_reg == BAND_QUAD |-> status_word[`ST_PORTB_BIT] == PORTB_LIGHTPIPE)
        else $error("port B not lightpipe at quad rate");

    a_spdif_cross: assert property (
        sample_valid && standalone_reg && band_reg == BAND_SINGLE
        |=> coax_spdif_out == $past(optical_spdif_in))
        else $error("coax output not fed from optical S/PDIF");

    a_input_only_thru: assert property (
        sample_valid && standalone_reg && mode_reg == MODE_INPUT_ONLY
        && band_reg == BAND_SINGLE && !vol_assign_reg[0]
        |=> out_valid && analog_out[0] == $past(analog_in[0]))
        else $error("analog input not passed to analog output");

    a_knob_max_clear: assert property (
        sample_valid && standalone_reg && mode_reg == MODE_INPUT_ONLY
        && volume_knob == `KNOB_MAX
        |=> analog_out[1] == $past(analog_in[1]))
        else $error("attenuation applied at full knob");

    a_unmapped_silent: assert property (
        sample_valid && (band_reg == BAND_QUAD || !standalone_reg)
        |=> analog_out[7] == '0 && optical_a_out[5] == '0)
        else $error("unmapped channel not silent");

    a_double_split: assert property (
        sample_valid && standalone_reg && band_reg == BAND_DOUBLE
        && portb_eff == PORTB_LIGHTPIPE
        |=> optical_b_out[0] == $past(analog_in[4])
            && optical_a_out[3] == $past(analog_in[3]))
        else $error("double-rate split wrong");

    a_quad_split: assert property (
        sample_valid && standalone_reg && band_reg == BAND_QUAD
        |=> optical_b_out[1] == $past(analog_in[3])
            && optical_b_out[2] == '0)
        else $error("quad-rate split wrong");

    a_stall_shape: assert property (
        (read || write) && waitrequest && !$past(read || write)
        |-> s_stall_then_take)
        else $error("stall sequence broken");

endmodule : standalone_converter_router

// [verif/far_side_gear.sv]
// Behavioural model of the outboard optical and coaxial digital gear
`timescale 1ns/1ps

module far_side_gear #(
    parameter int SAMPLE_W = 24
) (
    // Clock and frame control
    input  wire logic                         sys_clk,
    input  wire logic                         next_frame,
    input  wire logic                         hold_frame,
    // Samples toward the router
    output logic      [7:0][SAMPLE_W-1:0]     lightpipe_a,
    output logic      [7:0][SAMPLE_W-1:0]     lightpipe_b,
    output logic      [1:0][SAMPLE_W-1:0]     coax_pair,
    output logic      [1:0][SAMPLE_W-1:0]     optic_pair
);
    initial begin
        lightpipe_a = '0;
        lightpipe_b = '0;
        coax_pair   = '0;
        optic_pair  = '0;
    end

    // Stale words are inverted each cycle that hold_frame is low, so a sample one cycle late never looks valid
    always @(posedge sys_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (next_frame) begin
                lightpipe_a[i] <= SAMPLE_W'($urandom());
                lightpipe_b[i] <= SAMPLE_W'($urandom());
                if (i < 2) begin
                    coax_pair[i]  <= SAMPLE_W'($urandom());
                    optic_pair[i] <= SAMPLE_W'($urandom());
                end
            end else if (!hold_frame) begin
                lightpipe_a[i] <= ~lightpipe_a[i];
                lightpipe_b[i] <= ~lightpipe_b[i];
                if (i < 2) begin
                    coax_pair[i]  <= ~coax_pair[i];
                    optic_pair[i] <= ~optic_pair[i];
                end
            end
        end
    end
endmodule : far_side_gear

// [verif/test_standalone_converter_router.sv]
// Self-checking bench for the standalone channel router
`timescale 1ns/1ps

module test_standalone_converter_router;
    import router_pkg::*;

    logic sys_clk, reset, read, write, waitrequest, sample_valid, out_valid;
    logic host_cable_present, standalone_active, next_frame;
    logic [3:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [7:0] volume_knob, vol;
    logic [2:0] sync_source, cfg_sync;
    logic [7:0][23:0] analog_in, oa_in, ob_in, an_next, oa_cp, ob_cp;
    logic [7:0][23:0] analog_out, optical_a_out, optical_b_out;
    logic [7:0][23:0] exp_an, exp_oa, exp_ob;
    logic [1:0][23:0] cx_in, os_in, cx_cp, os_cp, exp_cx, exp_os;
    logic [1:0][23:0] coax_spdif_out, optical_spdif_out;
    logic cfg_mode, cfg_portb, exp_alone;
    logic [1:0] cfg_band;
    int num_errors, check_count, cycles;

    standalone_converter_router dut (
        .sys_clk(sys_clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .host_cable_present(host_cable_present),
        .volume_knob(volume_knob), .sample_valid(sample_valid),
        .analog_in(analog_in), .optical_a_in(oa_in), .optical_b_in(ob_in),
        .coax_spdif_in(cx_in), .optical_spdif_in(os_in),
        .out_valid(out_valid), .analog_out(analog_out),
        .optical_a_out(optical_a_out), .optical_b_out(optical_b_out),
        .coax_spdif_out(coax_spdif_out),
        .optical_spdif_out(optical_spdif_out),
        .standalone_active(standalone_active), .sync_source(sync_source));

    far_side_gear gear (
        .sys_clk(sys_clk), .next_frame(next_frame), .hold_frame(sample_valid),
        .lightpipe_a(oa_in), .lightpipe_b(ob_in), .coax_pair(cx_in),
        .optic_pair(os_in));

    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] addr,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        address <= addr;
        writedata <= wd;
        write <= wr;
        read <= !wr;
        // Ends once waitrequest drops; only the hang guard ends a stuck wait
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        // Read data stands at the take edge itself
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    task automatic do_reset();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : do_reset

    function automatic void predict();
        int nch, sp, ch, slot;
        logic split, onb, xsp;
        logic [23:0] src;
        logic [31:0] prod;
        exp_an = '0;
        exp_oa = '0;
        exp_ob = '0;
        exp_cx = '0;
        exp_os = '0;
        if (!exp_alone) return;
        xsp = (cfg_band == 2'h0) || (cfg_band == 2'h1 && cfg_portb);
        split = (cfg_band == 2'h2) || (cfg_band == 2'h1 && !cfg_portb);
        nch = (cfg_band == 2'h0 || (cfg_band == 2'h1 && !cfg_portb)) ? 8 : 4;
        sp = (cfg_band == 2'h2) ? 2 : 4;
        for (ch = 0; ch < nch; ch++) begin
            onb = split && ch >= sp;
            slot = onb ? ch - sp : ch;
            if (onb) exp_ob[slot] = an_next[ch];
            else exp_oa[slot] = an_next[ch];
            src = cfg_mode ? an_next[ch] : (onb ? ob_cp[slot] : oa_cp[slot]);
            prod = src * volume_knob;
            exp_an[ch] = (vol[ch] && volume_knob != 8'hff) ? prod[31:8] : src;
        end
        if (xsp) begin
            exp_cx = os_cp;
            exp_os = cx_cp;
        end
    endfunction : predict

    task automatic frame(input logic [23:0] mask);
        @(posedge sys_clk);
        next_frame <= 1'b1;
        for (int i = 0; i < 8; i++) an_next[i] = $urandom() & mask;
        @(posedge sys_clk);
        next_frame <= 1'b0;
        sample_valid <= 1'b1;
        analog_in <= an_next;
        @(negedge sys_clk);
        oa_cp = oa_in;
        ob_cp = ob_in;
        cx_cp = cx_in;
        os_cp = os_in;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        analog_in <= ~an_next;
        @(negedge sys_clk);
        predict();
        check(out_valid, 1'b1);
        check(analog_out, exp_an);
        check(optical_a_out, exp_oa);
        check(optical_b_out, exp_ob);
        check(coax_spdif_out, exp_cx);
        check(optical_spdif_out, exp_os);
    endtask : frame

    task automatic set_cfg(input logic [1:0] band);
        bus(1'b1, 4'h0, {25'h0, cfg_sync, cfg_portb, band, cfg_mode});
    endtask : set_cfg

    initial begin
        reset = 1'b1;
        {read, write, sample_valid, next_frame, host_cable_present} = '0;
        address = 4'h0;
        writedata = 32'h0;
        volume_knob = 8'hff;
        analog_in = '0;
        num_errors = 0;
        check_count = 0;
        cycles = 0;
        void'($urandom(32'h692c));
        do_reset();
        exp_alone = 1'b1;
        vol = 8'hff;
        check(standalone_active, 1'b1);
        bus(1'b0, 4'h0, 32'h0);
        check(rd, 32'h8);
        bus(1'b0, 4'h4, 32'h0);
        check(rd, 32'hff);
        bus(1'b0, 4'h8, 32'h0);
        check(rd, 32'h3);
        bus(1'b0, 4'hc, 32'h0);
        check(rd, 32'h0);
        // Every mode, band and port B format, knob fully up
        for (int k = 0; k < 12; k++) begin
            cfg_mode = (k >= 6);
            cfg_band = 2'((k / 2) % 3);
            cfg_portb = k[0];
            cfg_sync = 3'($urandom());
            set_cfg(cfg_band);
            bus(1'b0, 4'h0, 32'h0);
            check(rd, {cfg_sync, cfg_portb, cfg_band, cfg_mode});
            check(sync_source, cfg_sync);
            bus(1'b0, 4'h8, 32'h0);
            check(rd, {cfg_band, (cfg_band == 2'h0) ? 1'b1 :
                  (cfg_band == 2'h2) ? 1'b0 : cfg_portb, 1'b1});
            repeat (2) frame(24'hffffff);
        end
        set_cfg(2'h3);
        bus(1'b0, 4'h0, 32'h0);
        check(rd, {cfg_sync, cfg_portb, 2'h2, cfg_mode});
        // Attenuation, positive samples only so the shift is unambiguous
        {cfg_mode, cfg_band, cfg_portb} = 4'b1001;
        set_cfg(cfg_band);
        vol = 8'h5a;
        bus(1'b1, 4'h4, {24'h0, vol});
        bus(1'b0, 4'h4, 32'h0);
        check(rd, 32'h5a);
        volume_knob <= 8'h80;
        frame(24'h7fffff);
        volume_knob <= 8'hff;
        frame(24'h7fffff);
        vol = 8'h00;
        bus(1'b1, 4'h4, 32'h0);
        volume_knob <= 8'h40;
        frame(24'h7fffff);
        // Host cable present at power-up: router stays silent
        host_cable_present <= 1'b1;
        do_reset();
        exp_alone = 1'b0;
        check(standalone_active, 1'b0);
        frame(24'hffffff);
        bus(1'b0, 4'h8, 32'h0);
        check(rd[0], 1'b0);
        tally_and_finish();
    end
endmodule : test_standalone_converter_router
